// ---- bus_partner.sv ----
// Far-side model: external bus device, hold and ready source, mode straps
module bus_partner #(
    parameter logic [15:0] RD_VALUE = 16'h5AA5
) (
    input  wire logic        core_clk,
    input  wire logic        read_strobe_o,
    input  wire logic [15:0] bus_pins_oe_b,
    input  wire logic        hold_cmd,
    input  wire logic        slow,
    input  wire logic [2:0]  mode_cfg,
    output logic             hold_request_in,
    output logic             ready_in,
    output logic [2:0]       mode_pins,
    output logic [15:0]      bus_pins_i = 16'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    assign hold_request_in = hold_cmd;
    // Slow device keeps ready low while the read strobe is active
    assign ready_in = !(slow && !read_strobe_o);
    assign mode_pins = mode_cfg;
    // Bus shows the inverse unless read strobe is active with the bus released, so stale data never passes for a reply
    always @(posedge core_clk) begin
        if (!read_strobe_o && &bus_pins_oe_b) begin
            bus_pins_i <= RD_VALUE;
        end else begin
            bus_pins_i <= ~RD_VALUE;
        end
    end
endmodule // bus_partner

// ---- multi_function_pin_select.sv ----
// Multi-function pin selection for serial, PPG and external bus pins
`include "pin_select_map.svh"
module multi_function_pin_select
    import pin_select_pkg::*;
(
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    input  wire logic                        clk_en,
    // Control bits from software
    input  wire logic                        p7_bit3_func_select,
    input  wire logic [`PA_PPG_PINS-1:0]     porta_func_select_reg,
    input  wire logic                        write_strobe_enable,
    input  wire logic                        hold_enable,
    input  wire logic                        ready_enable,
    input  wire logic                        clock_out_enable,
    input  wire logic [`HIGH_ADDR_PINS-1:0]  high_addr_out_ctrl_reg,
    input  wire logic                        ext_bus_mode,
    input  wire logic                        multiplex_mode,
    input  wire logic                        bus_16bit,
    input  wire logic [2:0]                  serial_mode_ch4,
    // Peripheral side
    input  wire logic                        serial_clock_ch4,
    input  wire logic                        serial_out_ch4,
    input  wire logic [`PA_PPG_PINS-1:0]     pulse_gen_out,
    input  wire logic                        bus_cycle,
    input  wire logic                        bus_read,
    input  wire logic                        bus_write_low,
    input  wire logic                        bus_write_high,
    input  wire logic [`BUS_PINS-1:0]        bus_addr,
    input  wire logic [`BUS_PINS-1:0]        bus_wdata,
    input  wire logic [`HIGH_ADDR_PINS-1:0]  bus_high_addr,
    input  wire logic                        hold_grant,
    input  wire logic                        machine_clk,
    // Port data and direction registers
    input  wire logic [7:0]                  port_data,
    input  wire logic [7:0]                  port_dir,
    input  wire logic [`BUS_PINS-1:0]        port_bus_data,
    input  wire logic [`BUS_PINS-1:0]        port_bus_dir,
    input  wire logic [`HIGH_ADDR_PINS-1:0]  port2_data,
    input  wire logic [`HIGH_ADDR_PINS-1:0]  port2_dir,
    input  wire logic [`PA_PPG_PINS-1:0]     porta_data,
    input  wire logic [`PA_PPG_PINS-1:0]     porta_dir,
    // Pin inputs
    input  wire logic                        hold_request_in,
    input  wire logic                        ready_in,
    input  wire logic                        conv_trigger_in,
    input  wire logic [`MODE_PINS-1:0]       mode_pins,
    input  wire logic [`BUS_PINS-1:0]        bus_pins_i,
    // Pin outputs, enables active low
    output logic                             p73_o,
    output logic                             p73_oe_b,
    output logic                             p72_o,
    output logic                             p72_oe_b,
    output logic [`PA_PPG_PINS-1:0]          porta_o,
    output logic [`PA_PPG_PINS-1:0]          porta_oe_b,
    output logic                             addr_latch_o,
    output logic                             addr_latch_oe_b,
    output logic                             read_strobe_o,
    output logic                             read_strobe_oe_b,
    output logic                             low_write_strobe,
    output logic                             low_write_strobe_oe_b,
    output logic                             high_write_strobe,
    output logic                             high_write_strobe_oe_b,
    output logic                             hold_ack_out,
    output logic                             hold_ack_out_oe_b,
    output logic                             clk_out_o,
    output logic                             clk_out_oe_b,
    output logic [`BUS_PINS-1:0]             bus_pins_o,
    output logic [`BUS_PINS-1:0]             bus_pins_oe_b,
    output logic [`HIGH_ADDR_PINS-1:0]       port2_o,
    output logic [`HIGH_ADDR_PINS-1:0]       port2_oe_b,
    // Status to the core
    output logic                             hold_req_seen,
    output logic                             ready_seen,
    output logic                             conv_trigger,
    output logic                             ext_interrupt_in_18,
    output logic [`MODE_PINS-1:0]            mode_value,
    output logic [`BUS_PINS-1:0]             bus_rdata,
    output bus_phase_t                       bus_phase
);
    logic                 hold_sync;
    logic                 ready_sync;
    logic                 trig_sync;
    logic [`MODE_PINS-1:0] mode_sync;
    logic [`BUS_PINS-1:0] bus_sync;
    logic                 trig_prev;
    logic                 ser_clk_o;
    logic                 ser_clk_oe_b;
    logic                 ser_dat_o;
    logic                 ser_dat_oe_b;
    bus_phase_t           next_bus_phase;

    pin_sync #(.WIDTH(3)) u_sync_ctl (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .pin_in   ({hold_request_in, ready_in, conv_trigger_in}),
        .pin_out  ({hold_sync, ready_sync, trig_sync})
    );

    pin_sync #(.WIDTH(`MODE_PINS + `BUS_PINS)) u_sync_dat (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .pin_in   ({mode_pins, bus_pins_i}),
        .pin_out  ({mode_sync, bus_sync})
    );

    // Channel 4 serial on port 7 bits 3 and 2
    serial_pin_mux u_ser4 (
        .routed        (p7_bit3_func_select),
        .serial_mode   (serial_mode_ch4),
        .sclk_out      (serial_clock_ch4),
        .sdata_out     (serial_out_ch4),
        .port_clk_data (port_data[3]),
        .port_clk_dir  (port_dir[3]),
        .port_dat_data (port_data[2]),
        .port_dat_dir  (port_dir[2]),
        .clk_pin_o     (ser_clk_o),
        .clk_pin_oe_b  (ser_clk_oe_b),
        .dat_pin_o     (ser_dat_o),
        .dat_pin_oe_b  (ser_dat_oe_b)
    );

    // Pin drivers registered so data outputs come from flip-flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            p73_o    <= 1'b0;
            p73_oe_b <= 1'b1;
            p72_o    <= 1'b0;
            p72_oe_b <= 1'b1;
        end else if (clk_en) begin
            p73_o    <= ser_clk_o;
            p73_oe_b <= ser_clk_oe_b;
            p72_o    <= ser_dat_o;
            p72_oe_b <= ser_dat_oe_b;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            porta_o    <= '0;
            porta_oe_b <= '1;
        end else if (clk_en) begin
            for (int i = 0; i < `PA_PPG_PINS; i++) begin
                if (porta_func_select_reg[i]) begin
                    porta_o[i]    <= pulse_gen_out[i];
                    porta_oe_b[i] <= 1'b0;
                end else begin
                    porta_o[i]    <= porta_data[i];
                    porta_oe_b[i] <= ~porta_dir[i];
                end
            end
        end
    end

    // Port 5 control pins
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_latch_o           <= 1'b0;
            addr_latch_oe_b        <= 1'b1;
            read_strobe_o          <= 1'b1;
            read_strobe_oe_b       <= 1'b1;
            low_write_strobe       <= 1'b1;
            low_write_strobe_oe_b  <= 1'b1;
            high_write_strobe      <= 1'b1;
            high_write_strobe_oe_b <= 1'b1;
            hold_ack_out           <= 1'b1;
            hold_ack_out_oe_b      <= 1'b1;
            clk_out_o              <= 1'b0;
            clk_out_oe_b           <= 1'b1;
        end else if (clk_en) begin
            if (ext_bus_mode) begin
                addr_latch_o     <= (next_bus_phase == phase_addr);
                addr_latch_oe_b  <= 1'b0;
                read_strobe_o    <= ~(bus_cycle && bus_read);
                read_strobe_oe_b <= 1'b0;
            end else begin
                addr_latch_o     <= port_data[0];
                addr_latch_oe_b  <= ~port_dir[0];
                read_strobe_o    <= port_data[1];
                read_strobe_oe_b <= ~port_dir[1];
            end
            if (ext_bus_mode && write_strobe_enable) begin
                low_write_strobe      <= ~(bus_cycle && bus_write_low);
                low_write_strobe_oe_b <= 1'b0;
            end else begin
                low_write_strobe      <= port_data[2];
                low_write_strobe_oe_b <= ~port_dir[2];
            end
            if (ext_bus_mode && write_strobe_enable && bus_16bit) begin
                high_write_strobe      <= ~(bus_cycle && bus_write_high);
                high_write_strobe_oe_b <= 1'b0;
            end else begin
                high_write_strobe      <= port_data[3];
                high_write_strobe_oe_b <= ~port_dir[3];
            end
            if (ext_bus_mode && hold_enable) begin
                hold_ack_out      <= ~hold_grant;
                hold_ack_out_oe_b <= 1'b0;
            end else begin
                hold_ack_out      <= port_data[5];
                hold_ack_out_oe_b <= ~port_dir[5];
            end
            if (ext_bus_mode && clock_out_enable) begin
                clk_out_o    <= machine_clk;
                clk_out_oe_b <= 1'b0;
            end else begin
                clk_out_o    <= port_data[7];
                clk_out_oe_b <= ~port_dir[7];
            end
        end
    end
    // Hold request and ready only sampled when their pins are enabled
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_req_seen <= 1'b0;
            ready_seen    <= 1'b1;
        end else if (clk_en) begin
            hold_req_seen <= ext_bus_mode && hold_enable && hold_sync;
            ready_seen    <= !(ext_bus_mode && ready_enable) || ready_sync;
        end
    end
    // Bus phase sequencing for multiplexed and non-multiplexed cycles
    always_comb begin
        next_bus_phase = phase_idle;
        case (bus_phase)
            phase_idle: next_bus_phase = bus_cycle ?
                (multiplex_mode ? phase_addr : phase_data) : phase_idle;
            phase_addr: next_bus_phase = phase_data;
            phase_data: next_bus_phase = bus_cycle ? phase_data : phase_idle;
            default:    next_bus_phase = phase_idle;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) bus_phase <= phase_idle;
        else if (clk_en) bus_phase <= ext_bus_mode ? next_bus_phase : phase_idle;
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_pins_o    <= '0;
            bus_pins_oe_b <= '1;
        end else if (clk_en) begin
            if (ext_bus_mode && next_bus_phase == phase_addr) begin
                bus_pins_o    <= bus_addr;
                bus_pins_oe_b <= '0;
            end else if (ext_bus_mode && next_bus_phase == phase_data) begin
                // Data phase in both multiplex and non-multiplex mode; released for reads
                bus_pins_o    <= bus_wdata;
                bus_pins_oe_b <= bus_read ? '1 : '0;
            end else if (ext_bus_mode) begin
                bus_pins_o    <= '0;
                bus_pins_oe_b <= '1;
            end else begin
                bus_pins_o    <= port_bus_data;
                bus_pins_oe_b <= ~port_bus_dir;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) bus_rdata <= '0;
        else if (clk_en) bus_rdata <= bus_sync;
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            port2_o    <= '0;
            port2_oe_b <= '1;
        end else if (clk_en) begin
            for (int i = 0; i < `HIGH_ADDR_PINS; i++) begin
                if (ext_bus_mode && !high_addr_out_ctrl_reg[i]) begin
                    port2_o[i]    <= bus_high_addr[i];
                    port2_oe_b[i] <= 1'b0;
                end else begin
                    port2_o[i]    <= port2_data[i];
                    port2_oe_b[i] <= ~port2_dir[i];
                end
            end
        end
    end
    // Shared trigger pin: rising edge starts conversion, level to irq
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            trig_prev           <= 1'b0;
            conv_trigger        <= 1'b0;
            ext_interrupt_in_18 <= 1'b0;
        end else if (clk_en) begin
            trig_prev           <= trig_sync;
            conv_trigger        <= trig_sync && !trig_prev;
            ext_interrupt_in_18 <= trig_sync;
        end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) mode_value <= '0;
        else if (clk_en) mode_value <= mode_sync;
    end
    a_porta_ppg: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && porta_func_select_reg[0] |=> porta_oe_b[0] == 1'b0)
        else $error("port A pin 0 not driven for PPG");
    a_write_off: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && !write_strobe_enable
        |=> low_write_strobe_oe_b == !$past(port_dir[2]))
        else $error("low write strobe not port when disabled");
    a_high_strobe: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && ext_bus_mode && write_strobe_enable && !bus_16bit
        && !port_dir[3] |=> high_write_strobe_oe_b)
        else $error("high strobe driven on 8-bit bus");
    a_hold_off: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && !hold_enable |=> !hold_req_seen)
        else $error("hold request seen while disabled");
    a_ready_off: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && !ready_enable |=> ready_seen)
        else $error("ready sampled while disabled");
    a_clk_out: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && ext_bus_mode && clock_out_enable |=> !clk_out_oe_b)
        else $error("clock output not driven");
    a_high_addr: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && ext_bus_mode && !high_addr_out_ctrl_reg[0]
        |=> port2_o[0] == $past(bus_high_addr[0]))
        else $error("high address bit not output");
    a_addr_phase: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && bus_phase == phase_addr && ext_bus_mode
        |-> addr_latch_o && !bus_pins_oe_b[0])
        else $error("address phase without latch enable");
    a_serial_pin: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && p7_bit3_func_select && serial_mode_ch4 <= `SER_MODE_MAX_SIO
        |=> !p73_oe_b && p73_o == $past(serial_clock_ch4))
        else $error("serial clock not on port 7 bit 3");
endmodule // multi_function_pin_select

// ---- pin_select_map.svh ----
// Constants for the multi-function pin select block
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH
`define SER_MODE_I2C      3'h4
`define SER_MODE_MAX_SIO  3'h3
`define P7_FS_BIT         3
`define PA_PPG_PINS       4
`define BUS_PINS          16
`define HIGH_ADDR_PINS    8
`define MODE_PINS         3
`define SYNC_STAGES       3
`define EXT_BUS_PIN_CTRL_REG_WRITE_EN     0
`define EXT_BUS_PIN_CTRL_REG_HOLD_EN      1
`define EXT_BUS_PIN_CTRL_REG_READY_EN     2
`define EXT_BUS_PIN_CTRL_REG_CLK_EN       3
`endif

// ---- pin_select_pkg.sv ----
// Types shared by the pin select block
package pin_select_pkg;
    typedef enum logic [1:0] {
        phase_idle = 2'b00,
        phase_addr = 2'b01,
        phase_data = 2'b10
    } bus_phase_t;
endpackage

// ---- pin_sync.sv ----
// Three-stage synchroniser with agreement filter
`include "pin_select_map.svh"
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Elaboration-time refusal of an empty synchroniser
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync width must be positive");
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else if (clk_en) begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Change accepted only when stages two and three agree
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) pin_out[i] <= stage3[i];
            end
        end
    end
endmodule // pin_sync

// ---- serial_pin_mux.sv ----
// Serial clock/data pin steering for one channel
`include "pin_select_map.svh"
module serial_pin_mux (
    input  wire logic       routed,
    input  wire logic [2:0] serial_mode,
    input  wire logic       sclk_out,
    input  wire logic       sdata_out,
    input  wire logic       port_clk_data,
    input  wire logic       port_clk_dir,
    input  wire logic       port_dat_data,
    input  wire logic       port_dat_dir,
    output logic            clk_pin_o,
    output logic            clk_pin_oe_b,
    output logic            dat_pin_o,
    output logic            dat_pin_oe_b
);
    logic i2c;
    logic sio;
    assign i2c = (serial_mode == `SER_MODE_I2C);
    assign sio = (serial_mode <= `SER_MODE_MAX_SIO);

    always_comb begin
        clk_pin_o    = port_clk_data;
        clk_pin_oe_b = ~port_clk_dir;
        dat_pin_o    = port_dat_data;
        dat_pin_oe_b = ~port_dat_dir;
        if (routed && sio) begin
            clk_pin_o    = sclk_out;
            clk_pin_oe_b = 1'b0;
            dat_pin_o    = sdata_out;
            dat_pin_oe_b = 1'b0;
        end else if (routed && i2c) begin
            // Open drain: only drive low, release for high
            clk_pin_o    = 1'b0;
            clk_pin_oe_b = sclk_out;
            dat_pin_o    = 1'b0;
            dat_pin_oe_b = sdata_out;
        end
    end
endmodule // serial_pin_mux

// ---- testbench.sv ----
// Self-checking bench for the multi-function pin select block
module testbench
    import pin_select_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, rst_b = 0, clk_en = 1, hold_grant = 0;
    logic        p7_bit3_func_select = 0, write_strobe_enable = 0;
    logic        hold_enable = 0, ready_enable = 0, clock_out_enable = 0;
    logic        ext_bus_mode = 0, multiplex_mode = 0, bus_16bit = 0;
    logic        serial_clock_ch4 = 0, serial_out_ch4 = 0, bus_cycle = 0;
    logic        bus_read = 0, bus_write_low = 0, bus_write_high = 0;
    logic        machine_clk = 0, conv_trigger_in = 0, hold_cmd = 0, slow = 0;
    logic [2:0]  serial_mode_ch4 = 0, mode_cfg = 0, mode_pins, mode_value;
    logic [3:0]  porta_func_select_reg = 0, pulse_gen_out = 0;
    logic [3:0]  porta_data = 0, porta_dir = 0, porta_o, porta_oe_b;
    logic [7:0]  high_addr_out_ctrl_reg = 8'hFF, bus_high_addr = 0;
    logic [7:0]  port_data = 0, port_dir = 0, port2_data = 0, port2_dir = 0;
    logic [7:0]  port2_o, port2_oe_b;
    logic [15:0] bus_addr = 0, bus_wdata = 0, port_bus_data = 0;
    logic [15:0] port_bus_dir = 0, bus_pins_i, bus_pins_o, bus_pins_oe_b;
    logic [15:0] bus_rdata;
    logic        hold_request_in, ready_in, p73_o, p73_oe_b, p72_o, p72_oe_b;
    logic        addr_latch_o, addr_latch_oe_b, read_strobe_o;
    logic        read_strobe_oe_b, low_write_strobe, low_write_strobe_oe_b;
    logic        high_write_strobe, high_write_strobe_oe_b, hold_ack_out;
    logic        hold_ack_out_oe_b, clk_out_o, clk_out_oe_b, hold_req_seen;
    logic        ready_seen, conv_trigger, ext_interrupt_in_18;
    bus_phase_t  bus_phase;
    int          err_total = 0, comparisons = 0;

    multi_function_pin_select DUT (.*);
    bus_partner far (.*);

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input string n, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task end_of_test;
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic t_serial;
        for (int m = 0; m < 6; m++) begin
            @(posedge core_clk);
            p7_bit3_func_select <= 1'b1;
            serial_mode_ch4 <= m[2:0];
            serial_clock_ch4 <= 1'b1;
            serial_out_ch4 <= 1'b1;
            port_dir <= 8'h08;
            settle(2);
            chk("p73_oe_b", p73_oe_b, m == 4);
            chk("p73_o", p73_o, m < 4);
            chk("p72_o", p72_o, m < 4);
            chk("p72_oe_b", p72_oe_b, m >= 4);
        end
        @(posedge core_clk);
        p7_bit3_func_select <= 1'b0;
        serial_mode_ch4 <= 3'h0;
        settle(2);
        chk("p73_o", p73_o, 0);
        chk("p73_oe_b", p73_oe_b, 0);
    endtask

    task automatic t_porta;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            porta_func_select_reg <= 4'h1 << i;
            pulse_gen_out <= 4'hF;
            porta_dir <= 4'h0;
            settle(2);
            chk("porta_o", porta_o, 4'h1 << i);
            chk("porta_oe_b", porta_oe_b, 4'hF ^ (4'h1 << i));
        end
    endtask

    task automatic t_pins;
        @(posedge core_clk);
        ext_bus_mode <= 1'b1;
        port_data <= 8'hA4;
        port_dir <= 8'hFF;
        hold_cmd <= 1'b1;
        settle(8);
        chk("wrl", low_write_strobe, 1);
        chk("hak", hold_ack_out, 1);
        chk("hold_seen", hold_req_seen, 0);
        chk("clk_out", clk_out_o, 1);
        chk("clk_oe_b", clk_out_oe_b, 0);
        @(posedge core_clk);
        hold_enable <= 1'b1;
        clock_out_enable <= 1'b1;
        port_data <= 8'h00;
        machine_clk <= 1'b1;
        hold_grant <= 1'b1;
        settle(8);
        chk("hold_seen", hold_req_seen, 1);
        chk("hak", hold_ack_out, 0);
        chk("clk_out", clk_out_o, 1);
        chk("wrl", low_write_strobe, 0);
        @(posedge core_clk);
        hold_cmd <= 1'b0;
        hold_grant <= 1'b0;
        hold_enable <= 1'b0;
        clock_out_enable <= 1'b0;
    endtask

    task automatic t_wr(input logic wide);
        @(posedge core_clk);
        multiplex_mode <= 1'b1;
        write_strobe_enable <= 1'b1;
        bus_16bit <= wide;
        port_data <= 8'hFF;
        port_dir <= 8'h00;
        bus_addr <= 16'h1234;
        bus_wdata <= 16'hA5C3;
        bus_write_low <= 1'b1;
        bus_write_high <= 1'b1;
        bus_cycle <= 1'b1;
        settle(1);
        chk("ale", addr_latch_o, 1);
        chk("bus_o", bus_pins_o, 16'h1234);
        chk("phase", bus_phase, phase_addr);
        settle(1);
        chk("ale", addr_latch_o, 0);
        chk("bus_o", bus_pins_o, 16'hA5C3);
        chk("wrl", low_write_strobe, 0);
        chk("wrh", high_write_strobe, !wide);
        chk("wrh_oe_b", high_write_strobe_oe_b, !wide);
        @(posedge core_clk);
        bus_cycle <= 1'b0;
        multiplex_mode <= 1'b0;
        settle(2);
        chk("phase", bus_phase, phase_idle);
        @(posedge core_clk);
        bus_wdata <= 16'h0F1E;
        bus_cycle <= 1'b1;
        settle(1);
        chk("phase", bus_phase, phase_data);
        chk("ale", addr_latch_o, 0);
        chk("bus_o", bus_pins_o, 16'h0F1E);
        @(posedge core_clk);
        bus_cycle <= 1'b0;
        bus_write_low <= 1'b0;
        bus_write_high <= 1'b0;
    endtask

    task automatic t_rd(input logic en);
        @(posedge core_clk);
        ready_enable <= en;
        slow <= 1'b1;
        multiplex_mode <= 1'b1;
        bus_read <= 1'b1;
        bus_cycle <= 1'b1;
        settle(2);
        chk("rd", read_strobe_o, 0);
        chk("bus_oe_b", bus_pins_oe_b, 16'hFFFF);
        settle(9);
        chk("rdata", bus_rdata, 16'h5AA5);
        chk("ready", ready_seen, !en);
        @(posedge core_clk);
        bus_cycle <= 1'b0;
        bus_read <= 1'b0;
        slow <= 1'b0;
        settle(8);
        chk("rd", read_strobe_o, 1);
        chk("rdata", bus_rdata, 16'hA55A);
    endtask

    task automatic t_misc;
        int n;
        n = 0;
        @(posedge core_clk);
        high_addr_out_ctrl_reg <= 8'hF0;
        bus_high_addr <= 8'h5A;
        port2_data <= 8'h3C;
        port2_dir <= 8'hFF;
        conv_trigger_in <= 1'b1;
        mode_cfg <= 3'h5;
        repeat (12) begin
            @(posedge core_clk);
            #1;
            n += int'(conv_trigger === 1'b1);
        end
        chk("port2_o", port2_o, 8'h3A);
        chk("port2_oe_b", port2_oe_b, 8'h00);
        chk("trig_pulses", n[15:0], 1);
        chk("irq18", ext_interrupt_in_18, 1);
        chk("mode", mode_value, 3'h5);
        // Enable low must freeze the synchronisers and pin registers
        @(posedge core_clk);
        clk_en <= 1'b0;
        mode_cfg <= 3'h2;
        port2_data <= 8'hC3;
        settle(8);
        chk("mode", mode_value, 3'h5);
        chk("port2_o", port2_o, 8'h3A);
        @(posedge core_clk);
        clk_en <= 1'b1;
        settle(8);
        chk("mode", mode_value, 3'h2);
        chk("port2_o", port2_o, 8'hCA);
    endtask

    initial begin
        settle(10);
        chk("rd", read_strobe_o, 1);
        chk("bus_oe_b", bus_pins_oe_b, 16'hFFFF);
        chk("phase", bus_phase, phase_idle);
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        t_serial;
        t_porta;
        t_pins;
        t_wr(1'b1);
        t_wr(1'b0);
        t_rd(1'b1);
        t_rd(1'b0);
        t_misc;
        end_of_test;
    end

    // Whole run is about 160 cycles, so this only fires on a hang
    initial begin
        #50us;
        err_total++;
        end_of_test;
    end
endmodule // testbench
